// File: rtl/adcro_consts.svh
// Timing, counts and field positions for the converter's ready/data line control.
// Assumes counts are in master clocks of the block's own clock except where marked otherwise below.
`ifndef ADCRO_CONSTS_SVH
`define ADCRO_CONSTS_SVH

// Result word.
`define ADCRO_RESULT_BITS 24
`define ADCRO_RESULT_MSB 23

// Conversion cycle partition, as phase counts within one cycle.
`define ADCRO_CYCLE_LEN 384
`define ADCRO_READY_LEN 36
`define ADCRO_SERIAL_LEN 348
`define ADCRO_TRANSFER_LEN 6
`define ADCRO_PULSE_LOW_LEN 6
`define ADCRO_PRE_DATA_HIGH_LEN 6
`define ADCRO_FINAL_HIGH_LEN 24
`define ADCRO_LOW_START (`ADCRO_TRANSFER_LEN)
`define ADCRO_HIGH_START (`ADCRO_LOW_START + `ADCRO_PULSE_LOW_LEN)
`define ADCRO_SERIAL_START (`ADCRO_HIGH_START + `ADCRO_PRE_DATA_HIGH_LEN)
`define ADCRO_FINAL_START (`ADCRO_CYCLE_LEN - `ADCRO_FINAL_HIGH_LEN)

// Hold-high detection, in conversion cycles, and the sync pulse in master clocks.
`define ADCRO_SYNC_CYCLES 4
`define ADCRO_PD_CYCLES 20
`define ADCRO_SYNC_PULSE_LEN 3

// Holdoff times in half master clocks, as printed; counts round up to whole clocks.
`define ADCRO_SYNC_HOLD_X2 4085
`define ADCRO_PD_HOLD_X2 4637
`define ADCRO_MUX_HOLD_X2 4087
`define ADCRO_SYNC_HOLD ((`ADCRO_SYNC_HOLD_X2 + 1) / 2)
`define ADCRO_PD_HOLD ((`ADCRO_PD_HOLD_X2 + 1) / 2)
`define ADCRO_MUX_HOLD ((`ADCRO_MUX_HOLD_X2 + 1) / 2)

// Result buffer depth.
`define ADCRO_FIFO_DEPTH 8

`endif

// File: rtl/adcro_pkg.sv
// Types shared by the ready/data line control.
// Assumes the constants header is compiled alongside it.
package adcro_pkg;

   typedef enum logic [2:0] {
      ST_RUN        = 3'b000,
      ST_SYNC_PULSE = 3'b001,
      ST_SYNC_HOLD  = 3'b010,
      ST_POWER_DOWN = 3'b011,
      ST_HOLDOFF    = 3'b100
   } adcro_state_t;

endpackage : adcro_pkg

// File: rtl/adcro_sync.sv
// Two-flop synchroniser for pins that come from outside the clock domain.
// Assumes nothing reads the first stage but the second.
`timescale 1ns/1ps
module adcro_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic srst,
   // Pins and synchronised levels.
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] levelOut
);

   logic [WIDTH-1:0] stage1Q;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stage1Q <= '0;
         levelOut <= '0;
      end else begin
         stage1Q <= pinIn;
         levelOut <= stage1Q;
      end
   end

endmodule : adcro_sync

// File: rtl/adcro_fifo.sv
// Result buffer between the conversion source and the output holding register.
// Assumes writer and reader share the clock; both sides use valid and ready.
`timescale 1ns/1ps
module adcro_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic srst,
   // Filling side.
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   // Draining side.
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] memQ [DEPTH];
   logic [AW-1:0] wrPtrQ;
   logic [AW-1:0] rdPtrQ;
   logic [AW:0] countQ;
   logic push;
   logic pop;
   logic [AW:0] countD;

   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   assign outData = memQ[rdPtrQ];
   assign outValid = (countQ != '0);

   always_comb begin
      countD = countQ;
      if (push && !pop) begin
         countD = countQ + 1'b1;
      end else if (pop && !push) begin
         countD = countQ - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         memQ[wrPtrQ] <= inData;
      end
   end

   // Ready is registered from the next fill level so the source sees a clean level.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wrPtrQ <= '0;
         rdPtrQ <= '0;
         countQ <= '0;
         inReady <= 1'b0;
      end else begin
         if (push) begin
            wrPtrQ <= (wrPtrQ == AW'(DEPTH - 1)) ? '0 : wrPtrQ + 1'b1;
         end
         if (pop) begin
            rdPtrQ <= (rdPtrQ == AW'(DEPTH - 1)) ? '0 : rdPtrQ + 1'b1;
         end
         countQ <= countD;
         inReady <= (countD != (AW + 1)'(DEPTH));
      end
   end

endmodule : adcro_fifo

// File: rtl/adcro_shift_out.sv
// Ready indication and serial shift-out control of a delta-sigma converter's output pin.
// Assumes sys_clk is the converter's master clock and the shift clock and channel selects are raw pins.
`timescale 1ns/1ps
`include "adcro_consts.svh"
module adcro_shift_out #(
   parameter int WIDTH = `ADCRO_RESULT_BITS,
   parameter int DEPTH = `ADCRO_FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic srst,
   // Pins from the reading party.
   input wire logic shiftClkPin,
   input wire logic channelSelectLow,
   input wire logic channelSelectHigh,
   // Results from the decimation filter.
   input wire logic [WIDTH-1:0] resultData,
   input wire logic resultValid,
   output logic resultReady,
   // Pin and status towards the converter core.
   output logic readyDataLineQ,
   output logic readyIndicationModeQ,
   output logic modulatorResetQ,
   output logic powerDownQ
);

   localparam int PHASE_W = 9;
   localparam int PTR_W = 5;
   localparam int HOLD_W = 12;
   localparam int HIGH_W = 5;

   adcro_pkg::adcro_state_t stateQ;
   adcro_pkg::adcro_state_t stateD;
   logic [PHASE_W-1:0] phaseQ;
   logic [PTR_W-1:0] ptrQ;
   logic [HOLD_W-1:0] holdCntQ;
   logic [HIGH_W-1:0] highCntQ;
   logic [1:0] pulseCntQ;
   logic [WIDTH-1:0] outputHoldingRegQ;
   logic haveDataQ;
   logic [2:0] pinsS;
   logic shiftClkS;
   logic [1:0] chanSelS;
   logic shiftClkPrevQ;
   logic [1:0] chanSelPrevQ;
   logic shiftFall;
   logic chanChange;
   logic boundary;
   logic serialWin;
   logic [WIDTH-1:0] fifoData;
   logic fifoValid;
   logic fifoPop;
   logic lineD;

   // Picks the bit that the pointer selects; the last bit holds for one more shift, then the line goes low.
   function automatic logic serialBit(input logic [WIDTH-1:0] word, input logic [PTR_W-1:0] ptr);
      if (ptr < PTR_W'(WIDTH)) begin
         serialBit = word[PTR_W'(WIDTH - 1) - ptr];
      end else if (ptr == PTR_W'(WIDTH)) begin
         serialBit = word[0];
      end else begin
         serialBit = 1'b0;
      end
   endfunction : serialBit

   adcro_sync #(
      .WIDTH(3)
   ) u_sync (
      .sys_clk(sys_clk),
      .srst(srst),
      .pinIn({shiftClkPin, channelSelectHigh, channelSelectLow}),
      .levelOut(pinsS)
   );

   // Results queue here, one taken per conversion cycle; the filter stalls only while all DEPTH entries are full.
   adcro_fifo #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .srst(srst),
      .inData(resultData),
      .inValid(resultValid),
      .inReady(resultReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(fifoPop)
   );

   assign shiftClkS = pinsS[2];
   assign chanSelS = pinsS[1:0];
   assign shiftFall = shiftClkPrevQ && !shiftClkS;
   assign chanChange = (chanSelS != chanSelPrevQ);
   assign boundary = (phaseQ == PHASE_W'(`ADCRO_CYCLE_LEN - 1)) && (stateQ != adcro_pkg::ST_HOLDOFF);
   assign serialWin = (phaseQ >= PHASE_W'(`ADCRO_SERIAL_START)) && (phaseQ < PHASE_W'(`ADCRO_FINAL_START));
   assign fifoPop = (stateQ == adcro_pkg::ST_RUN) && (phaseQ == '0);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         shiftClkPrevQ <= 1'b0;
         chanSelPrevQ <= 2'h0;
      end else begin
         shiftClkPrevQ <= shiftClkS;
         chanSelPrevQ <= chanSelS;
      end
   end

   // The phase runs in every state but holdoff, so hold-high detection keeps cycle time.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         phaseQ <= '0;
      end else if (stateQ == adcro_pkg::ST_HOLDOFF || stateD == adcro_pkg::ST_HOLDOFF) begin
         phaseQ <= '0;
      end else if (boundary) begin
         phaseQ <= '0;
      end else begin
         phaseQ <= phaseQ + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         highCntQ <= '0;
      end else if (!shiftClkS) begin
         highCntQ <= '0;
      end else if (boundary && highCntQ != HIGH_W'(`ADCRO_PD_CYCLES)) begin
         highCntQ <= highCntQ + 1'b1;
      end
   end

   always_comb begin
      stateD = stateQ;
      unique case (stateQ)
         adcro_pkg::ST_RUN: begin
            if (boundary && shiftClkS && highCntQ == HIGH_W'(`ADCRO_SYNC_CYCLES)) begin
               stateD = adcro_pkg::ST_SYNC_PULSE;
            end else if (chanChange) begin
               stateD = adcro_pkg::ST_HOLDOFF;
            end
         end
         adcro_pkg::ST_SYNC_PULSE: begin
            if (pulseCntQ == 2'(`ADCRO_SYNC_PULSE_LEN - 1)) begin
               stateD = adcro_pkg::ST_SYNC_HOLD;
            end
         end
         adcro_pkg::ST_SYNC_HOLD: begin
            if (shiftFall) begin
               stateD = adcro_pkg::ST_HOLDOFF;
            end else if (boundary && shiftClkS && highCntQ == HIGH_W'(`ADCRO_PD_CYCLES)) begin
               stateD = adcro_pkg::ST_POWER_DOWN;
            end
         end
         adcro_pkg::ST_POWER_DOWN: begin
            if (shiftFall) begin
               stateD = adcro_pkg::ST_HOLDOFF;
            end
         end
         adcro_pkg::ST_HOLDOFF: begin
            if (holdCntQ <= HOLD_W'(1)) begin
               stateD = adcro_pkg::ST_RUN;
            end
         end
         default: begin
            stateD = adcro_pkg::ST_RUN;
         end
      endcase
   end

   // Power-up starts in holdoff so no ready pulse appears before the filter has settled.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stateQ <= adcro_pkg::ST_HOLDOFF;
      end else begin
         stateQ <= stateD;
      end
   end

   // Holdoff ends at transfer start, so the transfer time is taken off the load.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         holdCntQ <= HOLD_W'(`ADCRO_MUX_HOLD - `ADCRO_TRANSFER_LEN);
      end else if (stateQ != adcro_pkg::ST_HOLDOFF && stateD == adcro_pkg::ST_HOLDOFF) begin
         if (stateQ == adcro_pkg::ST_SYNC_HOLD) begin
            holdCntQ <= HOLD_W'(`ADCRO_SYNC_HOLD - `ADCRO_TRANSFER_LEN);
         end else if (stateQ == adcro_pkg::ST_POWER_DOWN) begin
            holdCntQ <= HOLD_W'(`ADCRO_PD_HOLD - `ADCRO_TRANSFER_LEN);
         end else begin
            holdCntQ <= HOLD_W'(`ADCRO_MUX_HOLD - `ADCRO_TRANSFER_LEN);
         end
      end else if (stateQ == adcro_pkg::ST_HOLDOFF && holdCntQ != '0) begin
         holdCntQ <= holdCntQ - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pulseCntQ <= 2'h0;
      end else if (stateQ == adcro_pkg::ST_SYNC_PULSE) begin
         pulseCntQ <= pulseCntQ + 1'b1;
      end else begin
         pulseCntQ <= 2'h0;
      end
   end

   // A cycle with no fresh result gives no ready pulse, so stale data is never offered.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         outputHoldingRegQ <= '0;
         haveDataQ <= 1'b0;
      end else if (stateQ != adcro_pkg::ST_RUN) begin
         haveDataQ <= 1'b0;
      end else if (fifoPop) begin
         outputHoldingRegQ <= fifoData;
         haveDataQ <= fifoValid;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ptrQ <= '0;
      end else if (phaseQ == '0 || phaseQ == PHASE_W'(`ADCRO_FINAL_START)) begin
         ptrQ <= '0;
      end else if (shiftFall && serialWin && stateQ == adcro_pkg::ST_RUN && ptrQ != '1) begin
         ptrQ <= ptrQ + 1'b1;
      end
   end

   always_comb begin
      lineD = 1'b1;
      if (stateQ == adcro_pkg::ST_SYNC_PULSE) begin
         lineD = 1'b0;
      end else if (stateQ == adcro_pkg::ST_RUN && haveDataQ) begin
         if (phaseQ >= PHASE_W'(`ADCRO_LOW_START) && phaseQ < PHASE_W'(`ADCRO_HIGH_START)) begin
            lineD = 1'b0;
         end else if (serialWin) begin
            lineD = serialBit(outputHoldingRegQ, ptrQ);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         readyDataLineQ <= 1'b1;
         readyIndicationModeQ <= 1'b0;
         modulatorResetQ <= 1'b0;
         powerDownQ <= 1'b0;
      end else begin
         readyDataLineQ <= lineD;
         readyIndicationModeQ <= (stateQ == adcro_pkg::ST_RUN) && !serialWin
            && (phaseQ >= PHASE_W'(`ADCRO_LOW_START) || phaseQ >= PHASE_W'(`ADCRO_FINAL_START));
         modulatorResetQ <= (stateQ == adcro_pkg::ST_SYNC_PULSE) || (stateQ == adcro_pkg::ST_SYNC_HOLD)
            || (stateQ == adcro_pkg::ST_POWER_DOWN);
         powerDownQ <= (stateQ == adcro_pkg::ST_POWER_DOWN);
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   a_transfer_high: assert property (
      $past(stateQ) == adcro_pkg::ST_RUN && $past(phaseQ) < 9'h006 |-> readyDataLineQ)
      else $error("Line low during result transfer.");

   a_ready_pulse: assert property (
      $past(stateQ) == adcro_pkg::ST_RUN && $past(haveDataQ) && $past(phaseQ) == 9'h006
      && stateQ == adcro_pkg::ST_RUN |-> !readyDataLineQ[*6] ##1 readyDataLineQ[*6])
      else $error("Ready pulse shape wrong.");

   a_cycle_wrap: assert property (
      phaseQ == 9'h17f && stateQ == adcro_pkg::ST_RUN && stateD == adcro_pkg::ST_RUN |=> phaseQ == 9'h000)
      else $error("Conversion cycle length wrong.");

   a_final_high: assert property (
      $past(stateQ) == adcro_pkg::ST_RUN && $past(phaseQ) >= 9'h168 |-> readyDataLineQ)
      else $error("Line low in final high interval.");

   a_overshift_low: assert property (
      $past(stateQ) == adcro_pkg::ST_RUN && $past(haveDataQ) && $past(serialWin) && $past(ptrQ) > 5'h18
      |-> !readyDataLineQ)
      else $error("Line not low after overshift.");

   a_ptr_reset: assert property (
      (phaseQ == 9'h000 || phaseQ == 9'h168) && !srst |=> ptrQ == 5'h00)
      else $error("Bit pointer not reset.");

   a_sync_pulse: assert property (
      $rose(stateQ == adcro_pkg::ST_SYNC_PULSE) |-> ##1 !readyDataLineQ[*3] ##1 readyDataLineQ)
      else $error("Sync pulse shape wrong.");

   a_pd_entry: assert property (
      $rose(powerDownQ) |-> highCntQ == 5'h14 && modulatorResetQ)
      else $error("Power-down entered early.");

   a_sync_holdoff: assert property (
      stateQ == adcro_pkg::ST_SYNC_HOLD && shiftFall |=> stateQ == adcro_pkg::ST_HOLDOFF
      && holdCntQ == 12'h7f5)
      else $error("Sync holdoff load wrong.");

   a_mux_holdoff: assert property (
      stateQ == adcro_pkg::ST_RUN && chanChange && stateD != adcro_pkg::ST_SYNC_PULSE
      |=> stateQ == adcro_pkg::ST_HOLDOFF && holdCntQ == 12'h7f6)
      else $error("Mux holdoff not started.");

   a_high_clear: assert property (
      !shiftClkS |=> highCntQ == 5'h00)
      else $error("High count not cleared.");

   c_sync: cover property ($rose(stateQ == adcro_pkg::ST_SYNC_PULSE));
   c_power_down: cover property ($rose(powerDownQ));
   c_full_read: cover property (ptrQ == 5'h18 && serialWin && haveDataQ);
   c_overshift: cover property (ptrQ == 5'h19 && serialWin && haveDataQ);

endmodule : adcro_shift_out

// File: sim/adcro_reader.sv
// Model of the reading controller: drives the shift clock and samples the ready/data line.
// Assumes a 1 ns time unit and that the caller starts each task just after a falling clock edge.
`timescale 1ns/1ps
`include "adcro_consts.svh"
module adcro_reader (
   // Link to the converter.
   input wire logic readyDataLineQ,
   output logic shiftClkPin
);
   // The shift clock idles low between frames.
   initial shiftClkPin = 1'b0;

   // Clocks n bits at a 48 ns period; bits past the word width are not kept.
   task automatic read_bits(input int n, output logic [23:0] got);
      got = 24'h000000;
      #1;
      for (int i = 0; i < n; i++) begin
         shiftClkPin = 1'b1;
         if (i < 24) got = {got[22:0], readyDataLineQ};
         #24;
         shiftClkPin = 1'b0;
         #24;
      end
   endtask : read_bits

   // Holds the shift clock high for whole conversion cycles, then drops it.
   task automatic hold_high(input int cycles);
      #1;
      shiftClkPin = 1'b1;
      #(cycles * `ADCRO_CYCLE_LEN * 4);
      shiftClkPin = 1'b0;
   endtask : hold_high
endmodule : adcro_reader

// File: sim/adc_ready_shift_out_control_bench.sv
// Self-checking bench for the ready/data line control, with a reading controller model.
// Assumes the design, its constants header and the reader model are compiled first.
`timescale 1ns/1ps
`include "adcro_consts.svh"
module adc_ready_shift_out_control_bench;
   logic sys_clk;
   logic srst;
   logic shiftClkPin;
   logic channelSelectLow;
   logic channelSelectHigh;
   logic [23:0] resultData;
   logic resultValid;
   logic resultReady;
   logic readyDataLineQ;
   logic readyIndicationModeQ;
   logic modulatorResetQ;
   logic powerDownQ;
   int n_errors;
   int n_tests;
   time t0;
   logic [23:0] w [8] = '{24'h800000, 24'h7fffff, 24'h000000, 24'ha5c3e1,
      24'h5a3c1e, 24'h3fffff, 24'hc35a96, 24'h000001};

   adcro_shift_out DUT (.sys_clk(sys_clk), .srst(srst), .shiftClkPin(shiftClkPin),
      .channelSelectLow(channelSelectLow), .channelSelectHigh(channelSelectHigh),
      .resultData(resultData), .resultValid(resultValid), .resultReady(resultReady),
      .readyDataLineQ(readyDataLineQ), .readyIndicationModeQ(readyIndicationModeQ),
      .modulatorResetQ(modulatorResetQ), .powerDownQ(powerDownQ));
   adcro_reader rdr (.readyDataLineQ(readyDataLineQ), .shiftClkPin(shiftClkPin));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   task automatic check(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("ERROR %0t: %s", $time, msg);
      end
   endtask : check

   // Every wait is bounded so a stuck line ends the run instead of hanging it.
   task automatic wait_lvl(input logic v, input int lim, output int n);
      n = 0;
      while (readyDataLineQ !== v) begin
         @(negedge sys_clk);
         n++;
         if (n > lim) begin
            check(1'b0, "line wait ran out");
            finish_test();
         end
      end
   endtask : wait_lvl

   task automatic run(input logic v, output int n);
      n = 0;
      while (readyDataLineQ === v && n < 9000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 9000) begin
         check(1'b0, "line level never ended");
         finish_test();
      end
   endtask : run

   // Leaves valid high so that back-to-back words need no extra edge.
   task automatic push(input logic [23:0] d);
      resultData = d;
      resultValid = 1'b1;
      for (int n = 0; resultReady !== 1'b1; n++) begin
         if (n > 50) begin
            check(1'b0, "result input never ready");
            finish_test();
         end
         @(negedge sys_clk);
      end
      @(negedge sys_clk);
   endtask : push

   task automatic pulse;
      int n;
      logic hi;
      // A held data bit can keep the line low, so the ready pulse is told apart by the mode flag.
      for (n = 0; !(readyDataLineQ === 1'b0 && readyIndicationModeQ === 1'b1); n++) begin
         if (n > 3000) begin
            check(1'b0, "ready pulse wait ran out");
            finish_test();
         end
         @(negedge sys_clk);
      end
      t0 = $time;
      run(1'b0, n);
      check(n == `ADCRO_PULSE_LOW_LEN, "ready pulse low length");
      hi = readyDataLineQ;
      repeat (5) begin
         @(negedge sys_clk);
         hi = hi & readyDataLineQ & readyIndicationModeQ;
      end
      check(hi, "high before serial output");
      repeat (8) @(negedge sys_clk);
      check(readyIndicationModeQ === 1'b0, "ready indication not ended");
   endtask : pulse

   task automatic full_read(input logic [23:0] d);
      logic [23:0] got;
      pulse();
      rdr.read_bits(24, got);
      check(got === d, "word read back");
      @(negedge sys_clk);
      check(readyDataLineQ === d[0], "last bit not kept");
   endtask : full_read

   task automatic t_reset;
      repeat (6) @(negedge sys_clk);
      check(readyDataLineQ === 1'b1 && resultReady === 1'b0, "reset levels");
      check(powerDownQ === 1'b0 && modulatorResetQ === 1'b0, "reset status");
      srst = 1'b0;
      $display("reset done");
   endtask : t_reset

   task automatic t_fill;
      repeat (2) @(negedge sys_clk);
      foreach (w[i]) push(w[i]);
      resultValid = 1'b0;
      @(negedge sys_clk);
      resultData = 24'h111111;
      resultValid = 1'b1;
      repeat (3) @(negedge sys_clk);
      check(resultReady === 1'b0, "full buffer still ready");
      resultValid = 1'b0;
      $display("fill done");
   endtask : t_fill

   task automatic t_full(input int first, input int last);
      for (int i = first; i <= last; i++) full_read(w[i]);
      $display("full reads done");
   endtask : t_full

   task automatic t_partial;
      logic [23:0] got;
      pulse();
      rdr.read_bits(5, got);
      check(got[4:0] === w[3][23:19], "partial bits");
      repeat (100) @(negedge sys_clk);
      check(readyDataLineQ === w[3][18], "partial read hold");
      $display("partial read done");
   endtask : t_partial

   task automatic t_over;
      logic [23:0] got;
      pulse();
      rdr.read_bits(26, got);
      check(got === w[4], "over-read word");
      @(negedge sys_clk);
      check(readyDataLineQ === 1'b0, "over-read level");
      $display("over-read done");
   endtask : t_over

   task automatic t_idle;
      int n;
      time ts;
      pulse();
      ts = t0;
      repeat (100) @(negedge sys_clk);
      check(readyDataLineQ === w[5][23], "MSB not held");
      wait_lvl(1'b1, 400, n);
      run(1'b1, n);
      check(n == `ADCRO_FINAL_HIGH_LEN + `ADCRO_TRANSFER_LEN, "final high");
      check($time - ts == `ADCRO_CYCLE_LEN * 4, "cycle length");
      $display("idle cycle done");
   endtask : t_idle

   task automatic t_empty;
      logic hi;
      hi = 1'b1;
      repeat (800) begin
         @(negedge sys_clk);
         hi = hi & readyDataLineQ;
      end
      check(hi, "pulse without a result");
      $display("empty buffer done");
   endtask : t_empty

   task automatic t_sync;
      int n;
      fork
         rdr.hold_high(6);
         begin
            wait_lvl(1'b0, 6 * `ADCRO_CYCLE_LEN, n);
            check(n >= 1537 && n <= 7679, "sync start");
            run(1'b0, n);
            check(n == `ADCRO_SYNC_PULSE_LEN && modulatorResetQ === 1'b1, "sync pulse");
         end
      join
      @(negedge sys_clk);
      push(24'h123456);
      resultValid = 1'b0;
      wait_lvl(1'b0, 2500, n);
      check(n >= 2040 && n <= 2052, "first pulse after sync");
      check(modulatorResetQ === 1'b0, "modulator still reset");
      full_read(24'h123456);
      $display("sync done");
   endtask : t_sync

   task automatic t_pd;
      int n;
      time ts;
      ts = $time;
      fork
         rdr.hold_high(22);
         begin
            wait_lvl(1'b1, 400, n);
            wait_lvl(1'b0, 6 * `ADCRO_CYCLE_LEN, n);
            t0 = $time;
            for (n = 0; powerDownQ !== 1'b1 && n < 9000; n++) @(negedge sys_clk);
            check(n >= 6143 && n <= 6147, "power-down after pulse");
            check(($time - ts) / 4 >= 7681, "power-down too early");
         end
      join
      @(negedge sys_clk);
      push(24'h6b5a4d);
      resultValid = 1'b0;
      wait_lvl(1'b0, 2600, n);
      check(n >= 2314 && n <= 2328 && powerDownQ === 1'b0, "wake pulse");
      full_read(24'h6b5a4d);
      $display("power-down done");
   endtask : t_pd

   task automatic t_mux;
      int n;
      push(24'h0f0f0f);
      resultValid = 1'b0;
      channelSelectLow = 1'b1;
      channelSelectHigh = 1'b1;
      wait_lvl(1'b0, 2500, n);
      check(n >= 2042 && n <= 2052, "mux holdoff");
      full_read(24'h0f0f0f);
      $display("mux change done");
   endtask : t_mux

   initial begin
      srst = 1'b1;
      channelSelectLow = 1'b0;
      channelSelectHigh = 1'b0;
      resultData = 24'h000000;
      resultValid = 1'b0;
      n_errors = 0;
      n_tests = 0;
      t_reset();
      t_fill();
      t_full(0, 2);
      t_partial();
      t_over();
      t_idle();
      t_full(6, 7);
      t_empty();
      t_sync();
      t_pd();
      t_mux();
      finish_test();
   end
endmodule : adc_ready_shift_out_control_bench
